// ==== src/dpsb_device.sv ====
// Dual-port synchronous memory, 8K x 9, with per-port burst counters
//
// How it works
// - Two independent ports, both reach any word
// - 8192 nine-bit words, 13-bit address, 9-bit data
// - Same-address double write leaves port 1's value
// - Mode select low flow-through, high pipelined
// - Pipelined adds output register; flow-through bypasses it
// - Controls, address, data registered on port edge
// - Selected only when low-enable low, high-enable high
// - Deselected port only flags power-down; its counter still tracks its pins
// - Pipelined outputs return after one selected cycle
// - Load strobe low loads external address into counter
// - Advance low increments counter each port edge
// - Load or clear overrides advance
// - Clear low forces counter to zero on each port edge
// - Counter wraps from top back to zero
// - Read-not-write low writes, high reads
// - Data pins driven on reads only with enable low
// - Write pulse self-timed, one system cycle
// - Works with free-running or gated port clock
// - Drive enable acts without the port clock
// - Deselect floats data after next port edge
`timescale 1ns/1ps
module dpsb_device
  import dpsb_pkg::*;
(
  input  wire logic  clk_sys,
  input  wire logic  rst,
  dpsb_if.dev        pins,
  output logic [1:0] port_powered_down,
  output logic [1:0] write_done
);
  // Whole device state: array, per-port output pipeline and write-done flags
  typedef struct packed {
    logic [DPSB_DEPTH-1:0][8:0] mem;
    logic [1:0][8:0]            pipe_data;
    logic [1:0]                 pipe_valid;
    logic [1:0]                 wr_seen;
  } dpsb_dev_t;

  dpsb_dev_t       st;
  dpsb_dev_t       next_st;
  dpsb_cap_t [1:0] cap;
  logic [1:0]      port_edge;
  logic [1:0][8:0] flow_data;

  // Port is writing in the cycle right after its capture
  function automatic logic wr_now(input dpsb_cap_t c);
    wr_now = c.fresh & c.sel & ~c.rnw;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Per-port input capture and counter, one copy per port
  generate
    for (genvar p = 0; p < DPSB_NPORT; p++)
    begin : g_port
      dpsb_port_capture u_cap (
        .clk_sys            (clk_sys),
        .rst                (rst),
        .port_clk           (pins.port_clk[p]),
        .select_low_n       (pins.select_low_n[p]),
        .select_high        (pins.select_high[p]),
        .addr_load_strobe_n (pins.addr_load_strobe_n[p]),
        .count_advance_n    (pins.count_advance_n[p]),
        .counter_clear_n    (pins.counter_clear_n[p]),
        .read_not_write     (pins.read_not_write[p]),
        .latency_mode_sel   (pins.latency_mode_sel[p]),
        .addr               (pins.addr[p]),
        .data_in            (pins.dq[p]),
        .port_edge          (port_edge[p]),
        .cap                (cap[p])
      );

      // Flow-through path reads the array at the registered address
      assign flow_data[p] = st.mem[cap[p].burst_addr];

      // Drivers: async enable, only for a selected read; pipeline needs a valid stage
      always_comb
      begin
        if (cap[p].pipe)
        begin
          pins.dev_dq_out[p] = st.pipe_data[p];
          pins.dev_dq_oe[p]  = cap[p].sel & st.pipe_valid[p]
                               & ~pins.drive_enable_n[p];
        end
        else
        begin
          pins.dev_dq_out[p] = flow_data[p];
          pins.dev_dq_oe[p]  = cap[p].sel & cap[p].rnw
                               & ~pins.drive_enable_n[p];
        end
      end

      // Deselected port is idle; its read path stays quiet
      assign port_powered_down[p] = ~cap[p].sel;
      assign write_done[p]        = st.wr_seen[p];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Array writes and output pipeline. A write lasts one system cycle, well
  // inside any port period, so the port clock's high time never matters.
  always_comb
  begin
    next_st         = st;
    next_st.wr_seen = 2'h0;
    for (int p = 0; p < DPSB_NPORT; p++)
    begin
      if (wr_now(cap[p]))
      begin
        // Right port lands last on a clash, so port 1's write is the one kept
        next_st.mem[cap[p].burst_addr] = cap[p].wdata;
        next_st.wr_seen[p]             = 1'b1;
      end
      if (port_edge[p])
      begin
        // Output register loads the read started at the previous edge
        next_st.pipe_data[p]  = flow_data[p];
        next_st.pipe_valid[p] = cap[p].sel & cap[p].rnw;
      end
    end
  end

  // Synchronous reset clears the array and the output stage
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      st <= '0;
    else
      st <= next_st;
  end
endmodule // dpsb_device

// ==== src/dpsb_host.sv ====
// Host end: drives both memory ports from a simple command port each
`timescale 1ns/1ps
module dpsb_host
  import dpsb_pkg::*;
(
  input  wire logic             clk_sys,
  input  wire logic             rst,
  dpsb_if.host                  pins,
  input  wire logic [1:0]       mode_pipe,
  input  wire logic [1:0]       cmd_valid,
  output logic [1:0]            cmd_ready,
  input  wire dpsb_op_t [1:0]   cmd_op,
  input  wire logic [1:0][12:0] cmd_addr,
  input  wire logic [1:0][8:0]  cmd_wdata,
  output logic [1:0]            rsp_valid,
  output logic [1:0][8:0]       rsp_data
);
  typedef struct packed {
    logic [3:0]       div;
    logic [1:0]       sel;
    logic [1:0]       ads_n;
    logic [1:0]       adv_n;
    logic [1:0]       clr_n;
    logic [1:0]       rnw;
    logic [1:0]       dq_oe;
    logic [1:0]       pipe;
    logic [1:0][12:0] addr;
    logic [1:0][8:0]  dout;
    logic [1:0][1:0]  rd_hist;
    logic [1:0]       rsp_valid;
    logic [1:0][8:0]  rsp_data;
  } dpsb_host_t;

  dpsb_host_t st;
  dpsb_host_t next_st;
  logic       fall;
  dpsb_op_t   op;

  // Pins change only one system cycle after the port clock fall, seven cycles before the edge
  assign fall = (st.div == DPSB_DIV_FALL);

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive straight from registers
  always_comb
  begin
    for (int p = 0; p < DPSB_NPORT; p++)
    begin
      pins.port_clk[p]           = (st.div < DPSB_DIV_FALL);
      pins.select_low_n[p]       = ~st.sel[p];
      pins.select_high[p]        = st.sel[p];
      pins.addr_load_strobe_n[p] = st.ads_n[p];
      pins.count_advance_n[p]    = st.adv_n[p];
      pins.counter_clear_n[p]    = st.clr_n[p];
      pins.read_not_write[p]     = st.rnw[p];
      pins.latency_mode_sel[p]   = st.pipe[p];
      // Enable stays off while the host drives, so a read-to-write turn never fights
      pins.drive_enable_n[p]     = (st.rd_hist[p] == DPSB_HIST_NONE) | st.dq_oe[p];
      pins.addr[p]               = st.addr[p];
      pins.host_dq_out[p]        = st.dout[p];
      pins.host_dq_oe[p]         = st.dq_oe[p];
      cmd_ready[p]               = fall;
      rsp_valid[p]               = st.rsp_valid[p];
      rsp_data[p]                = st.rsp_data[p];
    end
  end

  // One command per port period; read data is taken one fall (flow) or two later
  always_comb
  begin
    next_st           = st;
    next_st.div       = st.div + DPSB_DIV_ONE;
    next_st.rsp_valid = 2'h0;
    op                = DPSB_OP_IDLE;
    for (int p = 0; p < DPSB_NPORT; p++)
    begin
      if (fall)
      begin
        op = cmd_valid[p] ? cmd_op[p] : DPSB_OP_IDLE;
        if (st.pipe[p] ? st.rd_hist[p][1] : st.rd_hist[p][0])
        begin
          next_st.rsp_valid[p] = 1'b1;
          next_st.rsp_data[p]  = pins.dq[p];
        end
        next_st.pipe[p]  = mode_pipe[p];
        next_st.sel[p]   = (op != DPSB_OP_IDLE) && (op != DPSB_OP_CLEAR);
        next_st.ads_n[p] = ~((op == DPSB_OP_READ) || (op == DPSB_OP_WRITE));
        next_st.adv_n[p] = ~((op == DPSB_OP_BRD) || (op == DPSB_OP_BWR));
        next_st.clr_n[p] = (op != DPSB_OP_CLEAR);
        next_st.rnw[p]   = ~((op == DPSB_OP_WRITE) || (op == DPSB_OP_BWR));
        next_st.dq_oe[p] = ~next_st.rnw[p];
        next_st.addr[p]  = cmd_addr[p];
        next_st.dout[p]  = cmd_wdata[p];
        next_st.rd_hist[p] = {st.rd_hist[p][0], next_st.sel[p] & next_st.rnw[p]};
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      st <= '0;
    else
      st <= next_st;
  end
endmodule // dpsb_host

// ==== src/dpsb_if.sv ====
// Pin bundle joining the memory device end and its host end
`timescale 1ns/1ps
interface dpsb_if;
  import dpsb_pkg::*;
  logic [1:0]       port_clk;
  logic [1:0]       select_low_n;
  logic [1:0]       select_high;
  logic [1:0]       addr_load_strobe_n;
  logic [1:0]       count_advance_n;
  logic [1:0]       counter_clear_n;
  logic [1:0]       read_not_write;
  logic [1:0]       drive_enable_n;
  logic [1:0]       latency_mode_sel;
  logic [1:0][12:0] addr;
  logic [1:0][8:0]  host_dq_out;
  logic [1:0]       host_dq_oe;
  logic [1:0][8:0]  dev_dq_out;
  logic [1:0]       dev_dq_oe;
  logic [1:0][8:0]  dq;

  // Wire level of each data bus; an undriven bus reads as zero
  always_comb
  begin
    for (int p = 0; p < DPSB_NPORT; p++)
    begin
      dq[p] = dev_dq_oe[p] ? dev_dq_out[p] : (host_dq_oe[p] ? host_dq_out[p] : 9'h000);
    end
  end

  modport dev (
    input  port_clk, select_low_n, select_high, addr_load_strobe_n, count_advance_n,
    input  counter_clear_n, read_not_write, drive_enable_n, latency_mode_sel, addr, dq,
    output dev_dq_out, dev_dq_oe
  );
  modport host (
    output port_clk, select_low_n, select_high, addr_load_strobe_n, count_advance_n,
    output counter_clear_n, read_not_write, drive_enable_n, latency_mode_sel, addr,
    output host_dq_out, host_dq_oe,
    input  dq
  );
endinterface // dpsb_if

// ==== src/dpsb_pkg.sv ====
// Shared constants and types for the dual-port burst memory and its host
package dpsb_pkg;
  localparam int DPSB_AW    = 13;
  localparam int DPSB_DW    = 9;
  localparam int DPSB_DEPTH = 8192;
  localparam int DPSB_NPORT = 2;
  localparam logic [12:0] DPSB_ADDR_ZERO = 13'h0000;
  localparam logic [12:0] DPSB_ADDR_ONE  = 13'h0001;
  // Host port clock divider: high for counts below the fall point
  localparam logic [3:0] DPSB_DIV_FALL = 4'h8;
  localparam logic [3:0] DPSB_DIV_ONE  = 4'h1;
  localparam logic [1:0] DPSB_HIST_NONE = 2'h0;

  typedef enum logic [2:0] {
    DPSB_OP_IDLE  = 3'h0,
    DPSB_OP_READ  = 3'h1,
    DPSB_OP_WRITE = 3'h2,
    DPSB_OP_BRD   = 3'h3,
    DPSB_OP_BWR   = 3'h4,
    DPSB_OP_CLEAR = 3'h5
  } dpsb_op_t;

  // Per-port capture registers
  typedef struct packed {
    logic        clk_prev;
    logic        fresh;
    logic        sel;
    logic        rnw;
    logic        pipe;
    logic [12:0] burst_addr;
    logic [8:0]  wdata;
  } dpsb_cap_t;
endpackage

// ==== src/dpsb_port_capture.sv ====
// One port's input registers and burst address counter
`timescale 1ns/1ps
module dpsb_port_capture
  import dpsb_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        port_clk,
  input  wire logic        select_low_n,
  input  wire logic        select_high,
  input  wire logic        addr_load_strobe_n,
  input  wire logic        count_advance_n,
  input  wire logic        counter_clear_n,
  input  wire logic        read_not_write,
  input  wire logic        latency_mode_sel,
  input  wire logic [12:0] addr,
  input  wire logic [8:0]  data_in,
  output logic             port_edge,
  output dpsb_cap_t        cap
);
  dpsb_cap_t st;
  dpsb_cap_t next_st;

  // Rising port clock seen against its last level; a stopped clock gives no edge
  assign port_edge = port_clk & ~st.clk_prev;
  assign cap       = st;

  ////////////////////////////////////////////////////////////////////////////
  // Capture on the port edge; counter priority is clear, load, increment
  always_comb
  begin
    next_st          = st;
    next_st.clk_prev = port_clk;
    next_st.fresh    = port_edge;
    if (port_edge)
    begin
      next_st.sel   = ~select_low_n & select_high;
      next_st.rnw   = read_not_write;
      next_st.pipe  = latency_mode_sel;
      next_st.wdata = data_in;
      if (!counter_clear_n)
        next_st.burst_addr = DPSB_ADDR_ZERO;
      else if (!addr_load_strobe_n)
        next_st.burst_addr = addr;
      else if (!count_advance_n)
        next_st.burst_addr = st.burst_addr + DPSB_ADDR_ONE;
    end
  end

  // Registers every clock; deselected ports still track the counter pins
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      st <= '0;
    else
      st <= next_st;
  end
endmodule // dpsb_port_capture

// ==== tb/dpsb_props.sv ====
// Pin-level checks on the bundle joining the memory and its host
`timescale 1ns/1ps
module dpsb_props
  import dpsb_pkg::*;
(
  input wire logic            clk_sys,
  input wire logic            rst,
  input wire logic [1:0]       port_clk,
  input wire logic [1:0]       select_low_n,
  input wire logic [1:0]       select_high,
  input wire logic [1:0]       addr_load_strobe_n,
  input wire logic [1:0]       count_advance_n,
  input wire logic [1:0]       read_not_write,
  input wire logic [1:0]       drive_enable_n,
  input wire logic [1:0]       latency_mode_sel,
  input wire logic [1:0][12:0] addr,
  input wire logic [1:0]       host_dq_oe,
  input wire logic [1:0][8:0]  dev_dq_out,
  input wire logic [1:0]       dev_dq_oe
);
  logic [1:0] clk_q;
  logic [1:0] edge_q;
  logic [1:0] sel_q;
  wire  [1:0] pedge = port_clk & ~clk_q;
  wire  [1:0] sel   = ~select_low_n & select_high;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////////
  // Edge finder mirrors the device: previous level clears to 0 so the first
  // high cycle after reset counts as a port edge
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      clk_q  <= 2'h0;
      edge_q <= 2'h0;
      sel_q  <= 2'h0;
    end
    else
    begin
      clk_q  <= port_clk;
      edge_q <= pedge;
      sel_q  <= (pedge & sel) | (~pedge & sel_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Same checks on both ports
  for (genvar p = 0; p < 2; p++)
  begin : g_port
    a_oe_needs_enable: assert property (dev_dq_oe[p] |-> !drive_enable_n[p] && !host_dq_oe[p])
      else $error("data driven without enable or against host");
    a_flow_read_drive: assert property (pedge[p] && sel[p] && read_not_write[p]
      && !drive_enable_n[p] && !latency_mode_sel[p] |=> dev_dq_oe[p])
      else $error("flow read not driven next cycle");
    a_pipe_reactivate: assert property (pedge[p] && latency_mode_sel[p] && !sel_q[p]
      |=> !dev_dq_oe[p] [*8])
      else $error("pipelined output back too soon after deselect");
    a_desel_float: assert property (pedge[p] && !sel[p] |=> !dev_dq_oe[p] [*2])
      else $error("deselected port still drives");
    a_write_no_drive: assert property (pedge[p] && sel[p] && !read_not_write[p]
      && !latency_mode_sel[p] |=> !dev_dq_oe[p])
      else $error("device drives during write");
    a_out_hold: assert property (dev_dq_oe[p] && $past(dev_dq_oe[p]) && !edge_q[p]
      |-> $stable(dev_dq_out[p]))
      else $error("read data changed between port edges");
    a_normal_strobe: assert property (sel[p] |-> !addr_load_strobe_n[p] || !count_advance_n[p])
      else $error("selected cycle with neither load nor advance");
    a_pins_steady: assert property (port_clk[p] && clk_q[p] |-> $stable(addr[p])
      && $stable(sel[p]) && $stable(read_not_write[p]) && $stable(latency_mode_sel[p]))
      else $error("port pins moved while port clock high");
  end
endmodule // dpsb_props

// ==== tb/tb.sv ====
// Bench joining the memory and its host, driven through host commands
`timescale 1ns/1ps
module tb;
  import dpsb_pkg::*;
  logic             clk_sys;
  logic             rst;
  logic [1:0]       mode_pipe;
  logic [1:0]       cmd_valid;
  logic [1:0]       cmd_ready;
  dpsb_op_t [1:0]   cmd_op;
  logic [1:0][12:0] cmd_addr;
  logic [1:0][8:0]  cmd_wdata;
  logic [1:0]       rsp_valid;
  logic [1:0][8:0]  rsp_data;
  logic [1:0]       port_powered_down;
  logic [1:0]       write_done;
  logic [8:0]       rq [2][$];
  int               fails = 0;
  int               samples_checked = 0;
  int               cycles = 0;

  dpsb_if pins_if ();
  dpsb_device dpsb_device_i (.clk_sys(clk_sys), .rst(rst), .pins(pins_if.dev),
    .port_powered_down(port_powered_down), .write_done(write_done));
  dpsb_host dpsb_host_i (.clk_sys(clk_sys), .rst(rst), .pins(pins_if.host),
    .mode_pipe(mode_pipe), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  dpsb_props dpsb_props_i (.clk_sys(clk_sys), .rst(rst), .port_clk(pins_if.port_clk),
    .select_low_n(pins_if.select_low_n), .select_high(pins_if.select_high),
    .addr_load_strobe_n(pins_if.addr_load_strobe_n), .count_advance_n(pins_if.count_advance_n),
    .read_not_write(pins_if.read_not_write), .drive_enable_n(pins_if.drive_enable_n),
    .latency_mode_sel(pins_if.latency_mode_sel), .addr(pins_if.addr),
    .host_dq_oe(pins_if.host_dq_oe), .dev_dq_out(pins_if.dev_dq_out),
    .dev_dq_oe(pins_if.dev_dq_oe));

  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and comparison helpers
  task automatic summarize();
    if (fails == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [8:0] seen, input logic [8:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Offer a command at the falling edge inside the ready cycle, drop it after
  task automatic issue(input int p, input dpsb_op_t op, input logic [12:0] a,
                       input logic [8:0] d);
    @(negedge clk_sys);
    while (cmd_ready[p] !== 1'b1)
      @(negedge clk_sys);
    cmd_valid[p] = 1'b1;
    cmd_op[p]    = op;
    cmd_addr[p]  = a;
    cmd_wdata[p] = d;
    @(negedge clk_sys);
    cmd_valid[p] = 1'b0;
  endtask

  // The cycle ceiling below bounds this wait
  task automatic expect_rsp(input int p, input logic [8:0] exp, input string name);
    wait (rq[p].size() > 0);
    check(name, rq[p].pop_front(), exp);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, response collector and hang guard
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  always @(negedge clk_sys)
  begin
    for (int p = 0; p < 2; p++)
      if (rsp_valid[p] === 1'b1)
        rq[p].push_back(rsp_data[p]);
  end

  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      fails++;
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Burst writes with wrap and clear, then flow and pipelined read-back
  initial
  begin
    rst       = 1'b1;
    mode_pipe = 2'b00;
    cmd_valid = 2'b00;
    cmd_op[0] = DPSB_OP_IDLE;
    cmd_op[1] = DPSB_OP_IDLE;
    cmd_addr  = '0;
    cmd_wdata = '0;
    repeat (12) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'b0;
    // Address on advance and clear commands must be ignored
    fork
      begin
        issue(0, DPSB_OP_WRITE, 13'h1ffe, 9'h1a5);
        issue(0, DPSB_OP_BWR, 13'h0000, 9'h0c3);
        issue(0, DPSB_OP_BWR, 13'h0000, 9'h15a);
        issue(0, DPSB_OP_CLEAR, 13'h0abc, 9'h000);
        issue(0, DPSB_OP_BWR, 13'h0abc, 9'h0ff);
      end
      issue(1, DPSB_OP_WRITE, 13'h0800, 9'h077);
    join
    repeat (48) @(negedge clk_sys);
    check("powered_down", {7'h00, port_powered_down}, 9'h003);
    rq[0].delete();
    rq[1].delete();
    fork
      begin
        issue(1, DPSB_OP_READ, 13'h1ffe, 9'h000);
        issue(1, DPSB_OP_BRD, 13'h0000, 9'h000);
        issue(1, DPSB_OP_BRD, 13'h0000, 9'h000);
        issue(1, DPSB_OP_BRD, 13'h0000, 9'h000);
      end
      issue(0, DPSB_OP_READ, 13'h0800, 9'h000);
    join
    expect_rsp(1, 9'h1a5, "rd_1ffe");
    expect_rsp(1, 9'h0c3, "rd_1fff");
    expect_rsp(1, 9'h15a, "rd_0000");
    expect_rsp(1, 9'h0ff, "rd_0001");
    expect_rsp(0, 9'h077, "rd_0800");
    mode_pipe = 2'b10;
    issue(1, DPSB_OP_READ, 13'h1fff, 9'h000);
    issue(1, DPSB_OP_READ, 13'h0000, 9'h000);
    issue(1, DPSB_OP_READ, 13'h1ffe, 9'h000);
    expect_rsp(1, 9'h0c3, "pipe_1fff");
    expect_rsp(1, 9'h15a, "pipe_0000");
    // Last read's output edge meets a deselect, so the bus floats and reads zero
    expect_rsp(1, 9'h000, "pipe_float");
    summarize();
  end
endmodule // tb
